// File: line_sense_pkg.sv
// Constants for the line-sense and power-on configuration block.
// Assumes a 40 MHz clock and an 8-bit register port with 16-bit addresses.
package line_sense_pkg;
	localparam int CLK_KHZ = 40000;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int SENSE_W = 12;
	localparam int TIMER_W = 26;

	localparam logic [15:0] OFS_GAIN_TRIM = 16'hFE77;
	localparam logic [15:0] OFS_SETTING = 16'hFE78;
	localparam logic [15:0] OFS_POWER_ON = 16'hFE79;
	localparam logic [15:0] OFS_SENSE_VALUE = 16'hFED9;
	localparam logic [15:0] OFS_IRQ_STATUS = 16'hFE90;
	localparam logic [15:0] OFS_IRQ_MASK = 16'hFE91;
	localparam logic [15:0] OFS_LIVE_STATE = 16'hFE92;

	localparam logic [7:0] RST_GAIN_TRIM = 8'h00;
	localparam logic [7:0] RST_SETTING = 8'h00;
	localparam logic [7:0] RST_POWER_ON = 8'h00;
	localparam logic [3:0] RST_IRQ_MASK = 4'h0;

	// Gain trim fields
	localparam int TRIM_SIGN_BIT = 7;
	localparam int TRIM_MAG_LSB = 0;
	localparam int TRIM_MAG_W = 7;
	localparam int TRIM_SHIFT = 10;
	// Setting fields
	localparam int INCLUDE_BIT = 7;
	localparam int PG_DEB_BIT = 6;
	localparam int THRESH_LSB = 2;
	localparam int THRESH_W = 4;
	localparam int DEB_LSB = 0;
	// Power-on fields
	localparam int POLARITY_BIT = 7;
	localparam int SW_ON_BIT = 6;
	localparam int SOURCE_LSB = 4;
	localparam int ON_DLY_LSB = 2;
	localparam int OFF_DLY_LSB = 0;

	localparam logic [1:0] SRC_ALWAYS = 2'h0;
	localparam logic [1:0] SRC_PIN = 2'h1;
	localparam logic [1:0] SRC_SOFT = 2'h2;
	localparam logic [1:0] SRC_BOTH = 2'h3;

	// Interrupt status bits
	localparam int EV_FLAG_SET = 0;
	localparam int EV_FLAG_CLR = 1;
	localparam int EV_CH_ON = 2;
	localparam int EV_CH_OFF = 3;
	localparam int EV_W = 4;

	// Sense scale and hysteresis
	localparam int SENSE_FS_MV = 1600;
	localparam int HYST_MV = 75;
	localparam int HYST_CODES = (HYST_MV * (1 << SENSE_W)) / SENSE_FS_MV;

	// Times in microseconds and their cycle counts
	localparam int DEB_SHORT_US = 2600;
	localparam int DEB_MID_US = 10400;
	localparam int DEB_LONG_US = 100000;
	localparam int DLY_SHORT_US = 50000;
	localparam int DLY_MID_US = 250000;
	localparam int DLY_LONG_US = 1000000;
	localparam int DEB_SHORT_CYC = DEB_SHORT_US * CLK_KHZ / 1000;
	localparam int DEB_MID_CYC = DEB_MID_US * CLK_KHZ / 1000;
	localparam int DEB_LONG_CYC = DEB_LONG_US * CLK_KHZ / 1000;
	localparam int DLY_SHORT_CYC = DLY_SHORT_US * CLK_KHZ / 1000;
	localparam int DLY_MID_CYC = DLY_MID_US * CLK_KHZ / 1000;
	localparam int DLY_LONG_CYC = DLY_LONG_US * CLK_KHZ / 1000;

	typedef enum logic [1:0] {CH_OFF, CH_ON_WAIT, CH_ON, CH_OFF_WAIT} chan_state_t;
endpackage

// File: line_sense_config.sv
// Line-sense trim, threshold, debounce and first-channel power-on control.
// Assumes the sense reading comes from logic on clk; the request pin is asynchronous.
// How it works
// - Sign bit set subtracts trim, clear adds
// - Seven-bit magnitude sets gain correction amount
// - Include bit gates flag into both power-goods
// - Power-good debounce 0 or 2.6 ms
// - Threshold compared with four sense MSBs
// - 75 mV hysteresis on threshold compare
// - Zero threshold keeps flag cleared
// - Flag debounce 0, 2.6, 10.4, 100 ms
// - Polarity bit selects active pin level
// - Software bit turns channel on/off
// - Source field: always, pin, software
// - Source three needs pin and software
// - On delay before soft start
// - Off delay before turning off
module line_sense_config #(
	parameter int unsigned DEB_SHORT = line_sense_pkg::DEB_SHORT_CYC,
	parameter int unsigned DEB_MID = line_sense_pkg::DEB_MID_CYC,
	parameter int unsigned DEB_LONG = line_sense_pkg::DEB_LONG_CYC,
	parameter int unsigned DLY_SHORT = line_sense_pkg::DLY_SHORT_CYC,
	parameter int unsigned DLY_MID = line_sense_pkg::DLY_MID_CYC,
	parameter int unsigned DLY_LONG = line_sense_pkg::DLY_LONG_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [line_sense_pkg::ADDR_W-1:0] addr,
	input wire logic [line_sense_pkg::DATA_W-1:0] writeData,
	input wire logic writeStrobe,
	input wire logic readStrobe,
	output logic [line_sense_pkg::DATA_W-1:0] readData,
	input wire logic [line_sense_pkg::SENSE_W-1:0] senseReading,
	input wire logic powerOnRequestFirst,
	output logic acLineSenseFlag,
	output logic powerGoodFirstOk,
	output logic powerGoodSecondOk,
	output logic channelEnable,
	output logic softStartGo,
	output logic irq
);
	import line_sense_pkg::*;

	logic [7:0] gainTrim;
	logic [7:0] settingReg;
	logic [7:0] powerOnReg;
	logic [EV_W-1:0] irqStatus;
	logic [EV_W-1:0] irqMask;
	logic [7:0] next_gainTrim;
	logic [7:0] next_settingReg;
	logic [7:0] next_powerOnReg;
	logic [EV_W-1:0] next_irqStatus;
	logic [EV_W-1:0] next_irqMask;
	logic [7:0] next_readData;
	logic next_irq;
	logic [EV_W-1:0] events;

	logic [SENSE_W-1:0] trimmed;
	logic [SENSE_W-1:0] next_trimmed;
	logic rawFlag;
	logic next_rawFlag;
	logic [TIMER_W-1:0] debCount;
	logic [TIMER_W-1:0] next_debCount;
	logic next_acLineSenseFlag;
	logic [TIMER_W-1:0] pgCount;
	logic [TIMER_W-1:0] next_pgCount;
	logic pgFlag;
	logic next_pgFlag;
	logic next_pgOk;

	logic pinMeta;
	logic pinSync;
	logic request;
	chan_state_t chanState;
	chan_state_t next_chanState;
	logic [TIMER_W-1:0] dlyCount;
	logic [TIMER_W-1:0] next_dlyCount;
	logic next_channelEnable;
	logic next_softStartGo;

	// Register port
	always_comb begin
		next_gainTrim = gainTrim;
		next_settingReg = settingReg;
		next_powerOnReg = powerOnReg;
		next_irqMask = irqMask;
		next_irqStatus = irqStatus;
		next_readData = 8'h00;
		if (writeStrobe) begin
			case (addr)
				OFS_GAIN_TRIM: next_gainTrim = writeData;
				OFS_SETTING: next_settingReg = writeData;
				OFS_POWER_ON: next_powerOnReg = writeData;
				OFS_IRQ_MASK: next_irqMask = writeData[EV_W-1:0];
				default: ;
			endcase
		end
		if (readStrobe) begin
			case (addr)
				OFS_GAIN_TRIM: next_readData = gainTrim;
				OFS_SETTING: next_readData = settingReg;
				OFS_POWER_ON: next_readData = powerOnReg;
				OFS_SENSE_VALUE: next_readData = trimmed[SENSE_W-1 -: 8];
				OFS_IRQ_STATUS: begin
					next_readData = {4'h0, irqStatus};
					next_irqStatus = '0;
				end
				OFS_IRQ_MASK: next_readData = {4'h0, irqMask};
				OFS_LIVE_STATE: next_readData = {3'h0, pinSync, request, channelEnable,
					pgFlag, acLineSenseFlag};
				default: next_readData = 8'h00;
			endcase
		end
		// New events win over the read clear
		next_irqStatus = next_irqStatus | events;
		next_irq = |(next_irqStatus & next_irqMask);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gainTrim <= RST_GAIN_TRIM;
			settingReg <= RST_SETTING;
			powerOnReg <= RST_POWER_ON;
			irqMask <= RST_IRQ_MASK;
			irqStatus <= '0;
			readData <= 8'h00;
			irq <= 1'b0;
		end else begin
			gainTrim <= next_gainTrim;
			settingReg <= next_settingReg;
			powerOnReg <= next_powerOnReg;
			irqMask <= next_irqMask;
			irqStatus <= next_irqStatus;
			readData <= next_readData;
			irq <= next_irq;
		end
	end

	// Gain trim and threshold compare with hysteresis
	logic [SENSE_W+TRIM_MAG_W-1:0] product;
	logic [SENSE_W-1:0] correction;
	logic [SENSE_W:0] sum;
	logic [THRESH_W-1:0] thresh;
	logic [SENSE_W:0] setLevel;
	logic [SENSE_W:0] clearLevel;

	always_comb begin
		product = {{TRIM_MAG_W{1'b0}}, senseReading} *
			{{SENSE_W{1'b0}}, gainTrim[TRIM_MAG_LSB +: TRIM_MAG_W]};
		correction = SENSE_W'(product >> TRIM_SHIFT);
		// Trimmed value saturates at both ends
		if (gainTrim[TRIM_SIGN_BIT]) begin
			sum = {1'b0, senseReading} - {1'b0, correction};
			next_trimmed = sum[SENSE_W] ? '0 : sum[SENSE_W-1:0];
		end else begin
			sum = {1'b0, senseReading} + {1'b0, correction};
			next_trimmed = sum[SENSE_W] ? '1 : sum[SENSE_W-1:0];
		end
		thresh = settingReg[THRESH_LSB +: THRESH_W];
		setLevel = {1'b0, thresh, {(SENSE_W-THRESH_W){1'b0}}};
		clearLevel = setLevel + (SENSE_W+1)'(HYST_CODES);
		// Sets below the threshold, clears only at or above it plus hysteresis
		next_rawFlag = rawFlag;
		if (thresh == '0) begin
			next_rawFlag = 1'b0;
		end else if ({1'b0, trimmed} < setLevel) begin
			next_rawFlag = 1'b1;
		end else if ({1'b0, trimmed} >= clearLevel) begin
			next_rawFlag = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			trimmed <= '0;
			rawFlag <= 1'b0;
		end else begin
			trimmed <= next_trimmed;
			rawFlag <= next_rawFlag;
		end
	end

	// Flag debounce and power-good debounce
	logic [TIMER_W-1:0] debLimit;
	logic [TIMER_W-1:0] pgLimit;

	always_comb begin
		case (settingReg[DEB_LSB +: 2])
			2'h0: debLimit = '0;
			2'h1: debLimit = TIMER_W'(DEB_SHORT);
			2'h2: debLimit = TIMER_W'(DEB_MID);
			default: debLimit = TIMER_W'(DEB_LONG);
		endcase
		pgLimit = settingReg[PG_DEB_BIT] ? TIMER_W'(DEB_SHORT) : '0;
		next_acLineSenseFlag = acLineSenseFlag;
		// Count is cleared whenever raw returns to the held value
		next_debCount = '0;
		if (rawFlag != acLineSenseFlag) begin
			if (debCount + TIMER_W'(1) >= debLimit) begin
				next_acLineSenseFlag = rawFlag;
			end else begin
				next_debCount = debCount + TIMER_W'(1);
			end
		end
		next_pgFlag = pgFlag;
		next_pgCount = '0;
		if (acLineSenseFlag != pgFlag) begin
			if (pgCount + TIMER_W'(1) >= pgLimit) begin
				next_pgFlag = acLineSenseFlag;
			end else begin
				next_pgCount = pgCount + TIMER_W'(1);
			end
		end
		next_pgOk = !(settingReg[INCLUDE_BIT] && pgFlag);
	end

	// Status events on flag and channel edges
	always_comb begin
		events = '0;
		events[EV_FLAG_SET] = next_acLineSenseFlag && !acLineSenseFlag;
		events[EV_FLAG_CLR] = !next_acLineSenseFlag && acLineSenseFlag;
		events[EV_CH_ON] = next_channelEnable && !channelEnable;
		events[EV_CH_OFF] = !next_channelEnable && channelEnable;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			debCount <= '0;
			acLineSenseFlag <= 1'b0;
			pgCount <= '0;
			pgFlag <= 1'b0;
			powerGoodFirstOk <= 1'b1;
			powerGoodSecondOk <= 1'b1;
		end else begin
			debCount <= next_debCount;
			acLineSenseFlag <= next_acLineSenseFlag;
			pgCount <= next_pgCount;
			pgFlag <= next_pgFlag;
			powerGoodFirstOk <= next_pgOk;
			powerGoodSecondOk <= next_pgOk;
		end
	end

	// Request pin synchroniser
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pinMeta <= 1'b0;
			pinSync <= 1'b0;
		end else begin
			pinMeta <= powerOnRequestFirst;
			pinSync <= pinMeta;
		end
	end

	// On request source and on/off delays
	logic pinRequest;
	logic swRequest;
	logic [TIMER_W-1:0] onLimit;
	logic [TIMER_W-1:0] offLimit;

	function automatic logic [TIMER_W-1:0] delay_cycles(input logic [1:0] code);
		case (code)
			2'h0: delay_cycles = '0;
			2'h1: delay_cycles = TIMER_W'(DLY_SHORT);
			2'h2: delay_cycles = TIMER_W'(DLY_MID);
			default: delay_cycles = TIMER_W'(DLY_LONG);
		endcase
	endfunction

	always_comb begin
		pinRequest = pinSync ^ powerOnReg[POLARITY_BIT];
		swRequest = powerOnReg[SW_ON_BIT];
		case (powerOnReg[SOURCE_LSB +: 2])
			SRC_ALWAYS: request = 1'b1;
			SRC_PIN: request = pinRequest;
			SRC_SOFT: request = swRequest;
			SRC_BOTH: request = pinRequest && swRequest;
			default: request = 1'b0;
		endcase
		onLimit = delay_cycles(powerOnReg[ON_DLY_LSB +: 2]);
		offLimit = delay_cycles(powerOnReg[OFF_DLY_LSB +: 2]);
		next_chanState = chanState;
		next_dlyCount = '0;
		next_softStartGo = 1'b0;
		case (chanState)
			CH_OFF: begin
				if (request) begin
					if (onLimit == '0) begin
						next_chanState = CH_ON;
						next_softStartGo = 1'b1;
					end else begin
						next_chanState = CH_ON_WAIT;
					end
				end
			end
			CH_ON_WAIT: begin
				// Request dropping during the on delay cancels it
				if (!request) begin
					next_chanState = CH_OFF;
				end else if (dlyCount + TIMER_W'(1) >= onLimit) begin
					next_chanState = CH_ON;
					next_softStartGo = 1'b1;
				end else begin
					next_dlyCount = dlyCount + TIMER_W'(1);
				end
			end
			CH_ON: begin
				if (!request) begin
					next_chanState = (offLimit == '0) ? CH_OFF : CH_OFF_WAIT;
				end
			end
			CH_OFF_WAIT: begin
				// Request back during the off delay keeps the channel on
				if (request) begin
					next_chanState = CH_ON;
				end else if (dlyCount + TIMER_W'(1) >= offLimit) begin
					next_chanState = CH_OFF;
				end else begin
					next_dlyCount = dlyCount + TIMER_W'(1);
				end
			end
			default: next_chanState = CH_OFF;
		endcase
		next_channelEnable = (next_chanState == CH_ON) || (next_chanState == CH_OFF_WAIT);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			chanState <= CH_OFF;
			dlyCount <= '0;
			channelEnable <= 1'b0;
			softStartGo <= 1'b0;
		end else begin
			chanState <= next_chanState;
			dlyCount <= next_dlyCount;
			channelEnable <= next_channelEnable;
			softStartGo <= next_softStartGo;
		end
	end
endmodule

// File: line_sense_chk.sv
// Checker for the line-sense and power-on block, bound to its top module.
// Assumes registers are seen only through bus writes on the top ports.
module line_sense_chk
	import line_sense_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [line_sense_pkg::ADDR_W-1:0] addr,
	input wire logic [line_sense_pkg::DATA_W-1:0] writeData,
	input wire logic writeStrobe,
	input wire logic readStrobe,
	input wire logic [line_sense_pkg::DATA_W-1:0] readData,
	input wire logic powerOnRequestFirst,
	input wire logic acLineSenseFlag,
	input wire logic powerGoodFirstOk,
	input wire logic powerGoodSecondOk,
	input wire logic channelEnable,
	input wire logic softStartGo
);
	logic [7:0] setReg, pwrReg;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Shadow copies of the setting and power-on registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			setReg <= RST_SETTING;
			pwrReg <= RST_POWER_ON;
		end else if (writeStrobe && addr == OFS_SETTING) begin
			setReg <= writeData;
		end else if (writeStrobe && addr == OFS_POWER_ON) begin
			pwrReg <= writeData;
		end
	end
	chk_read_quiet: assert property (readData != 8'h00 |-> $past(readStrobe))
		else $error("stray read data");
	chk_start_pulse: assert property (softStartGo |=> !softStartGo)
		else $error("long start pulse");
	chk_start_on: assert property (softStartGo |-> channelEnable)
		else $error("start while off");
	chk_pg_twin: assert property (powerGoodFirstOk == powerGoodSecondOk)
		else $error("power good split");
	chk_pg_free: assert property ((!setReg[7])[*3] |-> powerGoodFirstOk)
		else $error("excluded flag blocks");
	chk_zero_thresh: assert property ((setReg[5:0] == 6'h00)[*5] |-> !acLineSenseFlag)
		else $error("flag with zero threshold");
	chk_always_on: assert property ((pwrReg[5:2] == 4'h0)[*3] |-> channelEnable)
		else $error("always-on channel off");
	chk_soft_on: assert property ((pwrReg[6:2] == 5'h18)[*3] |-> channelEnable)
		else $error("software on ignored");
	chk_soft_off: assert property ((pwrReg[6:4] == 3'h2 && pwrReg[1:0] == 2'h0)[*3] |-> !channelEnable)
		else $error("software off ignored");
	chk_both_off: assert property ((pwrReg[6:4] == 3'h3 && pwrReg[1:0] == 2'h0)[*3] |-> !channelEnable)
		else $error("pin alone turned on");
	chk_pin_on: assert property ((pwrReg[5:2] == 4'h4 && (powerOnRequestFirst ^ pwrReg[7]))[*6] |-> channelEnable)
		else $error("pin request ignored");
	cover property (softStartGo);
	cover property ($fell(powerGoodFirstOk));
	cover property ($fell(acLineSenseFlag));
endmodule

bind line_sense_config line_sense_chk u_chk (.clk, .rst_n, .addr, .writeData, .writeStrobe,
	.readStrobe, .readData, .powerOnRequestFirst, .acLineSenseFlag, .powerGoodFirstOk,
	.powerGoodSecondOk, .channelEnable, .softStartGo);

// File: supervisor_model.sv
// Supervisor driving the first channel's power-on request pin.
// Assumes the pin is push-pull; it follows the asked level after a lag.
module supervisor_model (
	input wire logic clk,
	input wire logic pinLevel,
	input wire logic [3:0] lag,
	output logic pin
);
	timeunit 1ns;
	timeprecision 1ps;
	initial pin = 1'b0;
	// Changes off the clock edge, as an unsynchronised source would
	always @(posedge clk) begin
		repeat (lag) @(posedge clk);
		#7 pin = pinLevel;
	end
endmodule

// File: tb_top.sv
// Self-checking bench for the line-sense and power-on block.
// Assumes short delay parameters; a supervisor model drives the request pin.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import line_sense_pkg::*;
	logic clk, rst_n, writeStrobe, readStrobe, pinLevel, powerOnRequestFirst;
	logic acLineSenseFlag, powerGoodFirstOk, powerGoodSecondOk, channelEnable, softStartGo, irq;
	logic [15:0] addr;
	logic [7:0] writeData, readData, v;
	logic [11:0] senseReading, e;
	logic [3:0] lag, t;
	int miscompares = 0;
	int num_checks = 0;
	int n;
	localparam int STEP = 10;
	int debN[4] = '{1, STEP, 2 * STEP, 4 * STEP};
	int dlyN[4] = '{0, 5 * STEP, 10 * STEP, 20 * STEP};
	line_sense_config #(.DEB_SHORT(STEP), .DEB_MID(2 * STEP), .DEB_LONG(4 * STEP),
		.DLY_SHORT(5 * STEP), .DLY_MID(10 * STEP), .DLY_LONG(20 * STEP)) u_dut (.clk, .rst_n,
		.addr, .writeData,
		.writeStrobe, .readStrobe, .readData, .senseReading, .powerOnRequestFirst,
		.acLineSenseFlag, .powerGoodFirstOk, .powerGoodSecondOk, .channelEnable,
		.softStartGo, .irq);
	supervisor_model u_sup (.clk, .pinLevel, .lag, .pin(powerOnRequestFirst));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		#500000;
		miscompares++;
		final_report();
	end
	task automatic final_report;
		if (miscompares == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		writeData <= d;
		writeStrobe <= 1'b1;
		@(posedge clk);
		writeStrobe <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		readStrobe <= 1'b1;
		@(posedge clk);
		readStrobe <= 1'b0;
		@(negedge clk);
		chk("readData", 16'(readData), 16'(exp));
	endtask
	function automatic logic sig(int sel);
		return sel == 0 ? acLineSenseFlag : sel == 1 ? channelEnable :
			sel == 2 ? softStartGo : powerGoodFirstOk;
	endfunction
	// Counts edges until the chosen output reaches the level
	task automatic cyc(input int sel, input logic lvl, output int k);
		k = 0;
		#1;
		while (k < 400 && sig(sel) !== lvl) begin
			@(posedge clk);
			#1;
			k++;
		end
	endtask
	task automatic step(input logic [11:0] x, input int code, input logic lvl);
		@(posedge clk);
		senseReading <= x;
		cyc(0, lvl, n);
		chk("flagDelay", 16'(n), 16'(2 + debN[code]));
	endtask
	function automatic logic [11:0] trimmed(logic [11:0] r, logic [7:0] g);
		int c, s;
		c = (r * g[6:0]) >> 10;
		s = g[7] ? r - c : r + c;
		return s < 0 ? 12'h000 : s > 4095 ? 12'hFFF : s[11:0];
	endfunction
	function automatic logic expEn(logic [7:0] c);
		logic hw;
		hw = c[0] ^ c[1];
		return c[4:3] == SRC_ALWAYS || (c[4:3] == SRC_PIN && hw) ||
			(c[4:3] == SRC_SOFT && c[2]) || (c[4:3] == SRC_BOTH && hw && c[2]);
	endfunction
	initial begin
		rst_n = 1'b0;
		{writeStrobe, readStrobe, pinLevel} = 3'h0;
		addr = 16'h0000;
		writeData = 8'h00;
		senseReading = 12'hFFF;
		lag = 4'h0;
		void'($urandom(59));
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rd(OFS_GAIN_TRIM, RST_GAIN_TRIM);
		rd(OFS_SETTING, RST_SETTING);
		rd(OFS_POWER_ON, RST_POWER_ON);
		rd(16'h1234, 8'h00);
		rd(OFS_IRQ_STATUS, 8'h04);
		rd(OFS_IRQ_STATUS, 8'h00);
		rd(OFS_LIVE_STATE, 8'h0C);
		for (int i = 0; i < 12; i++) begin
			v = i == 0 ? 8'h7F : i == 1 ? 8'hFF : 8'($urandom);
			e = i == 0 ? 12'hFFF : 12'($urandom);
			@(posedge clk);
			senseReading <= e;
			wr(OFS_GAIN_TRIM, v);
			wr(OFS_SENSE_VALUE, 8'h5A);
			e = trimmed(e, v);
			rd(OFS_GAIN_TRIM, v);
			rd(OFS_SENSE_VALUE, e[11:4]);
		end
		@(posedge clk);
		senseReading <= 12'hFFF;
		wr(OFS_GAIN_TRIM, 8'h00);
		wr(OFS_IRQ_MASK, 8'h01);
		rd(OFS_IRQ_MASK, 8'h01);
		wr(OFS_SETTING, 8'h20);
		step(12'h7FF, 0, 1'b1);
		repeat (2) @(posedge clk);
		#1 chk("irq", 16'(irq), 16'h0001);
		rd(OFS_IRQ_STATUS, 8'h01);
		@(posedge clk);
		senseReading <= 12'h8BF;
		repeat (6) @(posedge clk);
		#1 chk("flag", 16'(acLineSenseFlag), 16'h0001);
		step(12'h8C0, 0, 1'b0);
		repeat (2) @(posedge clk);
		#1 chk("irq", 16'(irq), 16'h0000);
		rd(OFS_IRQ_STATUS, 8'h02);
		for (int i = 0; i < 4; i++) begin
			t = 4'($urandom_range(15, 1));
			@(posedge clk);
			senseReading <= 12'hFFF;
			wr(OFS_SETTING, {2'h0, t, 2'(i)});
			step({t, 8'h00} - 12'h001, i, 1'b1);
			step({t, 8'h00} + 12'h0C0, i, 1'b0);
		end
		wr(OFS_SETTING, 8'h21);
		@(posedge clk);
		senseReading <= 12'h000;
		repeat (5) @(posedge clk);
		senseReading <= 12'hFFF;
		step(12'h000, 1, 1'b1);
		wr(OFS_SETTING, 8'h00);
		repeat (6) @(posedge clk);
		#1 chk("flag", 16'(acLineSenseFlag), 16'h0000);
		@(posedge clk);
		senseReading <= 12'hFFF;
		for (int i = 0; i < 2; i++) begin
			wr(OFS_SETTING, i ? 8'hE0 : 8'hA0);
			step(12'h000, 0, 1'b1);
			cyc(3, 1'b0, n);
			chk("pgDelay", 16'(n), 16'(1 + debN[i]));
			chk("pgSecond", 16'(powerGoodSecondOk), 16'h0000);
			step(12'hFFF, 0, 1'b0);
		end
		step(12'h000, 0, 1'b1);
		wr(OFS_SETTING, 8'h60);
		repeat (3) @(posedge clk);
		#1 chk("pgOk", 16'(powerGoodFirstOk), 16'h0001);
		for (int i = 0; i < 32; i++) begin
			v = 8'(i);
			@(posedge clk);
			pinLevel <= v[0];
			lag <= 4'($urandom_range(3));
			wr(OFS_POWER_ON, {v[1], v[2], v[4:3], 4'h0});
			repeat (12) @(posedge clk);
			#1 chk("enable", 16'(channelEnable), 16'(expEn(v)));
		end
		for (int i = 0; i < 4; i++) begin
			wr(OFS_POWER_ON, {4'h6, 2'(i), 2'(i)});
			cyc(2, 1'b1, n);
			chk("onDelay", 16'(n >= dlyN[i] + 1 && n <= dlyN[i] + 2), 16'h0001);
			wr(OFS_POWER_ON, {4'h2, 2'(i), 2'(i)});
			cyc(1, 1'b0, n);
			chk("offDelay", 16'(n >= dlyN[i] + 1 && n <= dlyN[i] + 2), 16'h0001);
		end
		final_report();
	end
endmodule
